// ---- bench/eew_dev_model.sv ----
// eew_dev_model.sv: behavioural byte-wide eeprom seen from its pins
// assumes pins change just after the rising clock edge; window and busy times shortened
`timescale 1ns/1ps
`include "eew_defines.vh"
module eew_dev_model #(
    parameter WIN = 40,
    parameter BUSY = 80
) (
    input wire clock,
    input wire [16:0] mem_addr,
    input wire [7:0] dq_out,
    output wire [7:0] dq_in,
    input wire chip_sel_n,
    input wire out_en_n,
    input wire write_n,
    input wire write_inhibit_n,
    output wire ready_busy_n
);
    reg [7:0] mem [0:131071];
    reg [16:0] aq [0:255];
    reg [7:0] dq [0:255];
    reg [7:0] q, last;
    reg wr_q, rd_q, tog, lock, p;
    integer n, idle, bcnt, wlow, s, i;
    wire wr = !chip_sel_n && !write_n && write_inhibit_n;
    wire rd = !chip_sel_n && !out_en_n && write_n && write_inhibit_n;
    // a released bus shows the inverse, so a stale byte never passes for fresh data
    assign dq_in = rd ? q : ~q;
    assign ready_busy_n = !(n > 0 || bcnt > 0);
    initial begin
        for (i = 0; i < 131072; i = i + 1)
            mem[i] = 8'hff;
        n = 0;
        bcnt = 0;
        wlow = 0;
        lock = 0;
        wr_q = 0;
        rd_q = 0;
    end
    // strobe sampling, page commit and status reads
    always @(posedge clock) begin
        if (!write_inhibit_n) begin
            n = 0;
            bcnt = 0;
        end
        if (wr && !wr_q)
            aq[n] = mem_addr;
        if (!wr && wr_q && wlow > 2) begin
            dq[n] = dq_out;
            n = n + 1;
            idle = 0;
        end
        wlow = wr ? wlow + 1 : 0;
        if (n > 0 && !wr)
            idle = idle + 1;
        if (n > 0 && idle >= WIN) begin
            p = n >= 3 && aq[0] == `EEW_CMD_A1 && dq[0] == `EEW_CMD_D1;
            p = p && aq[1] == `EEW_CMD_A2 && dq[1] == `EEW_CMD_D2;
            s = p ? 3 : 0;
            if (p && n == 6 && dq[2] == `EEW_UNLOCK_D3 && dq[5] == `EEW_UNLOCK_D6)
                lock = 0;
            else if (n > s && (!lock || (p && dq[2] == `EEW_LOCK_D3))) begin
                if (p)
                    lock = 1;
                for (i = s; i < n; i = i + 1)
                    mem[{aq[s][16:7], aq[i][6:0]}] = dq[i];
                last = dq[n - 1];
                tog = 1;
                bcnt = BUSY;
            end
            n = 0;
        end
        if (bcnt > 0)
            bcnt = bcnt - 1;
        if (rd && !rd_q) begin
            q = bcnt > 0 ? {~last[7], tog, 6'h00} : mem[mem_addr];
            tog = bcnt > 0 ? !tog : tog;
        end
        wr_q = wr;
        rd_q = rd;
    end
endmodule // eew_dev_model

// ---- bench/eew_host_props.sv ----
// eew_host_props.sv: pin-level checks on the eeprom write controller
// assumes it is bound into eew_host and sees its ports only
`timescale 1ns/1ps
module eew_host_props #(
    parameter WINDOW_CYC = 10000
) (
    input wire clock,
    input wire reset_n,
    input wire inhibit_req,
    input wire cmd_valid,
    input wire cmd_ready,
    input wire cmd_done,
    input wire cmd_error,
    input wire status_busy,
    input wire [16:0] mem_addr,
    input wire [7:0] dq_out,
    input wire dq_oe,
    input wire chip_sel_n,
    input wire out_en_n,
    input wire write_n,
    input wire write_inhibit_n
);
    reg [15:0] idle_reg;
    // cycles since the last write strobe; saturates so a long wait never wraps to zero
    always @(posedge clock or negedge reset_n) begin
        if (!reset_n)
            idle_reg <= 16'h0000;
        else if (!write_n)
            idle_reg <= 16'h0000;
        else if (idle_reg != 16'hffff)
            idle_reg <= idle_reg + 16'h0001;
    end
    default clocking cb @(posedge clock); endclocking
    default disable iff (!reset_n);
    wait_window_a: assert property (status_busy && $fell(out_en_n) |-> idle_reg >= WINDOW_CYC - 1)
        else $error("poll read before the load window ran out");
    inhibit_hold_a: assert property (!chip_sel_n |-> write_inhibit_n)
        else $error("inhibit low during a bus cycle");
    busy_inhibit_a: assert property (status_busy |-> write_inhibit_n)
        else $error("inhibit low while the write is finishing");
    inhibit_req_a: assert property (inhibit_req && !cmd_valid && cmd_ready |-> ##[1:3] !write_inhibit_n)
        else $error("inhibit request not obeyed");
    refuse_a: assert property (!write_inhibit_n |-> chip_sel_n && !cmd_ready)
        else $error("bus cycle or command offered while inhibited");
    strobe_width_a: assert property ($fell(write_n) |-> !write_n [*3])
        else $error("write strobe too short");
    data_hold_a: assert property ($rose(write_n) |-> dq_oe && $stable(dq_out))
        else $error("data not held at strobe rise");
    addr_stable_a: assert property (!write_n && !$past(write_n) |-> $stable(mem_addr))
        else $error("address moved under write strobe");
    cover property (cmd_done && !cmd_error);
    cover property (cmd_done && cmd_error);
    cover property ($fell(write_inhibit_n));
endmodule // eew_host_props

bind eew_host eew_host_props #(.WINDOW_CYC(WINDOW_CYC)) i_props (.clock, .reset_n, .inhibit_req, .cmd_valid,
    .cmd_ready, .cmd_done, .cmd_error, .status_busy, .mem_addr, .dq_out, .dq_oe, .chip_sel_n, .out_en_n, .write_n,
    .write_inhibit_n);

// ---- bench/eew_host_tb.sv ----
// eew_host_tb.sv: scenarios for the eeprom write controller against the device model
// assumes the model and checker are compiled first and the rtl include path is set
`timescale 1ns/1ps
module eew_host_tb;
    reg clock = 1'b0;
    reg reset_n = 1'b0;
    reg inhibit_req = 1'b0;
    reg soft_write_lock = 1'b0;
    reg cmd_valid = 1'b0;
    reg [1:0] cmd_op = 2'h0;
    reg [16:0] cmd_addr = 17'h0_0000;
    reg [7:0] cmd_len = 8'h00;
    reg load_valid = 1'b0;
    reg [7:0] load_data = 8'h00;
    wire cmd_ready, cmd_done, cmd_error, status_busy, load_ready, dq_oe, chip_sel_n, out_en_n, write_n;
    wire write_inhibit_n, ready_busy_n;
    wire [7:0] rd_data, dq_out, dq_in;
    wire [16:0] mem_addr;
    integer fail_count = 0;
    integer total_checks = 0;
    integer rb_lows = 0;
    integer busy_cycles = 0;
    always #5 clock = ~clock;
    always @(negedge ready_busy_n) rb_lows = rb_lows + 1;
    // counts cycles in which the controller reports a write in progress
    always @(posedge clock) if (status_busy === 1'b1) busy_cycles = busy_cycles + 1;
    // short window and write times keep the run brief
    eew_host #(.WRITE_CYC(200), .WINDOW_CYC(50)) i_dut (.clock, .reset_n, .inhibit_req, .soft_write_lock,
        .cmd_valid, .cmd_ready, .cmd_op, .cmd_addr, .cmd_len, .rd_data, .cmd_done, .cmd_error, .status_busy,
        .load_valid, .load_ready, .load_data, .mem_addr, .dq_out, .dq_oe, .dq_in, .chip_sel_n, .out_en_n,
        .write_n, .write_inhibit_n, .ready_busy_n);
    eew_dev_model i_dev (.clock, .mem_addr, .dq_out, .dq_in, .chip_sel_n, .out_en_n, .write_n,
        .write_inhibit_n, .ready_busy_n);
    task chk(input string nm, input [16:0] exp, input [16:0] got);
        begin
            total_checks = total_checks + 1;
            if (got !== exp) begin
                fail_count = fail_count + 1;
                $display("Error %s expected %h seen %h", nm, exp, got);
            end
        end
    endtask
    task conclude;
        begin
            $display("checks %0d mismatches %0d", total_checks, fail_count);
            if (fail_count == 0 && total_checks > 0)
                $display("All tests passed");
            else
                $display("Some tests failed");
            $finish;
        end
    endtask
    // one command with its byte stream; gap stalls before the last byte
    task run(input [1:0] op, input [16:0] a, input [7:0] n, input [7:0] b, input integer gap);
        integer i, k;
        reg seen;
        begin
            seen = 0;
            cmd_op <= op;
            cmd_addr <= a;
            cmd_len <= n;
            cmd_valid <= 1'b1;
            @(posedge clock);
            while (cmd_ready !== 1'b1) @(posedge clock);
            cmd_valid <= 1'b0;
            for (i = 0; i < n && !seen && (op == 2'd1 || op == 2'd2); i = i + 1) begin
                if (i == n - 1 && gap > 0) begin
                    load_valid <= 1'b0;
                    repeat (gap) @(posedge clock);
                end
                load_valid <= 1'b1;
                load_data <= b + i[7:0];
                @(posedge clock);
                while (load_ready !== 1'b1 && cmd_done !== 1'b1) @(posedge clock);
                seen = cmd_done === 1'b1;
            end
            load_valid <= 1'b0;
            for (k = 0; k < 20000 && !seen; k = k + 1) begin
                @(posedge clock);
                seen = cmd_done === 1'b1;
            end
            chk("cmd_done", 1, seen);
        end
    endtask
    task rd(input [16:0] a, input [7:0] e);
        begin
            run(2'd0, a, 8'd1, 8'h00, 0);
            chk("rd_data", e, rd_data);
        end
    endtask
    task t_reset;
        begin
            repeat (3) @(posedge clock);
            chk("write_inhibit_n", 0, write_inhibit_n);
            chk("write_n", 1, write_n);
            reset_n <= 1'b1;
            repeat (3) @(posedge clock);
            chk("cmd_ready", 1, cmd_ready);
        end
    endtask
    task t_page;
        integer r, b;
        begin
            r = rb_lows;
            b = busy_cycles;
            run(2'd1, 17'h0_0100, 8'd3, 8'h10, 0);
            chk("cmd_error", 0, cmd_error);
            chk("status_busy_seen", 1, busy_cycles > b);
            chk("status_busy", 0, status_busy);
            chk("busy_lows", r + 1, rb_lows);
            chk("ready_busy_n", 1, ready_busy_n);
            rd(17'h0_0100, 8'h10);
            rd(17'h0_0102, 8'h12);
        end
    endtask
    task t_full;
        begin
            run(2'd1, 17'h1_ff85, 8'd128, 8'h40, 0);
            chk("cmd_error", 0, cmd_error);
            rd(17'h1_ff84, 8'hbf);
            rd(17'h1_ff80, 8'hbb);
        end
    endtask
    task t_lock;
        begin
            soft_write_lock <= 1'b1;
            run(2'd2, 17'h0_0200, 8'd1, 8'hc3, 0);
            rd(17'h0_0200, 8'hc3);
            soft_write_lock <= 1'b0;
            run(2'd1, 17'h0_0200, 8'd1, 8'h5a, 0);
            rd(17'h0_0200, 8'hc3);
            soft_write_lock <= 1'b1;
            run(2'd1, 17'h0_0280, 8'd1, 8'h66, 0);
            rd(17'h0_0280, 8'h66);
            run(2'd3, 17'h0_0000, 8'd0, 8'h00, 0);
            rd(17'h0_5555, 8'hff);
            soft_write_lock <= 1'b0;
            run(2'd1, 17'h0_0300, 8'd1, 8'h77, 0);
            rd(17'h0_0300, 8'h77);
        end
    endtask
    task t_gap;
        begin
            run(2'd1, 17'h0_0380, 8'd2, 8'h21, 3100);
            chk("cmd_error", 1, cmd_error);
            rd(17'h0_0380, 8'h21);
        end
    endtask
    task t_inhibit;
        begin
            inhibit_req <= 1'b1;
            repeat (4) @(posedge clock);
            chk("write_inhibit_n", 0, write_inhibit_n);
            chk("cmd_ready", 0, cmd_ready);
            inhibit_req <= 1'b0;
            repeat (4) @(posedge clock);
            chk("cmd_ready", 1, cmd_ready);
        end
    endtask
    initial begin
        t_reset;
        t_page;
        t_full;
        t_lock;
        t_gap;
        t_inhibit;
        conclude;
    end
    // the scenarios need well under 20000 cycles; 100000 means a hang
    initial begin
        #1_000_000;
        fail_count = fail_count + 1;
        conclude;
    end
endmodule // eew_host_tb

// ---- rtl/eew_defines.vh ----
// eew_defines.vh: constants of the byte-wide eeprom write controller
// assumes a 100 MHz clock; included by bare name from the rtl modules
`ifndef EEW_DEFINES_VH
`define EEW_DEFINES_VH

`define EEW_CLK_NS 100'd10
// host timing figures, in their own units
`define EEW_STROBE_NS 300
`define EEW_BYTE_GAP_US 30
`define EEW_LOAD_WINDOW_US 100
`define EEW_WRITE_MS 10
`define EEW_GLITCH_NS 20
// cycle counts: strobe and glitch are least times (round up), byte gap a longest time (round down)
`define EEW_STROBE_CYC ((`EEW_STROBE_NS + 9) / 10)
`define EEW_GAP_CYC ((`EEW_BYTE_GAP_US * 1000) / 10 - 10)
`define EEW_WINDOW_CYC ((`EEW_LOAD_WINDOW_US * 1000) / 10)
`define EEW_WRITE_CYC ((`EEW_WRITE_MS * 1000000) / 10)
`define EEW_GLITCH_CYC ((`EEW_GLITCH_NS + 9) / 10 + 1)
`define EEW_PAGE_BYTES 128
`define EEW_PAGE_LSB 7
`define EEW_POLL_BIT 7
`define EEW_TOGGLE_BIT 6
// command sequence defaults (arbitrary, configurable)
`define EEW_CMD_A1 17'h0_5555
`define EEW_CMD_A2 17'h0_2AAA
`define EEW_CMD_D1 8'hAA
`define EEW_CMD_D2 8'h55
`define EEW_LOCK_D3 8'hA0
`define EEW_UNLOCK_D3 8'h80
`define EEW_UNLOCK_D6 8'h20

`endif

// ---- rtl/eew_host.v ----
// eew_host.v: host controller that writes pages to a byte-wide eeprom and waits out the write
// assumes all pins synchronous to clock; the pins need a pull-up on ready_busy_n outside
//
// Contract
// - host starts next load within 30 us
// - poll reads keep one fixed address
// - host holds inhibit high during operations
// - inhibit held high 10 ms after data
// - host avoids stray control pulses
// - locked writes need three-byte prefix
// - host reset drives write inhibit
`timescale 1ns/1ps
`include "eew_defines.vh"
module eew_host #(
    parameter WRITE_CYC = `EEW_WRITE_CYC,
    parameter WINDOW_CYC = `EEW_WINDOW_CYC,
    parameter [16:0] CMD_A1 = `EEW_CMD_A1,
    parameter [16:0] CMD_A2 = `EEW_CMD_A2,
    parameter [7:0] CMD_D1 = `EEW_CMD_D1,
    parameter [7:0] CMD_D2 = `EEW_CMD_D2,
    parameter [7:0] LOCK_D3 = `EEW_LOCK_D3,
    parameter [7:0] UNLOCK_D3 = `EEW_UNLOCK_D3,
    parameter [7:0] UNLOCK_D6 = `EEW_UNLOCK_D6
) (
    input wire clock,
    input wire reset_n,
    input wire inhibit_req,
    input wire soft_write_lock,
    input wire cmd_valid,
    output wire cmd_ready,
    input wire [1:0] cmd_op,
    input wire [16:0] cmd_addr,
    input wire [7:0] cmd_len,
    output reg [7:0] rd_data,
    output reg cmd_done,
    output reg cmd_error,
    output reg status_busy,
    input wire load_valid,
    output wire load_ready,
    input wire [7:0] load_data,
    output wire [16:0] mem_addr,
    output wire [7:0] dq_out,
    output wire dq_oe,
    input wire [7:0] dq_in,
    output wire chip_sel_n,
    output wire out_en_n,
    output wire write_n,
    output reg write_inhibit_n,
    input wire ready_busy_n
);
    // operations
    localparam OP_READ = 2'd0;
    localparam OP_PAGE = 2'd1;
    localparam OP_LOCK = 2'd2;
    localparam OP_UNLOCK = 2'd3;
    // states
    localparam S_IDLE = 3'd0;
    localparam S_CMD = 3'd1;
    localparam S_LOAD = 3'd2;
    localparam S_WAIT = 3'd3;
    localparam S_POLL = 3'd4;
    localparam S_READ = 3'd5;
    localparam S_DONE = 3'd6;

    reg [2:0] state_reg;
    reg [1:0] op_reg;
    reg [2:0] step_reg;
    reg [7:0] left_reg;
    reg [16:0] page_reg;
    reg [6:0] col_reg;
    reg [7:0] last_reg;
    reg [23:0] tmr_reg;
    reg toggle_prev_reg;
    reg first_poll_reg;
    reg go_reg;
    reg go_read_reg;
    reg [16:0] go_addr_reg;
    reg [7:0] go_data_reg;
    wire st_busy;
    wire st_done;
    wire [7:0] st_rdata;

    // returns the address of step n of a command prefix (lock: 3 steps, unlock: 6)
    function [16:0] seq_addr;
        input [2:0] n;
        begin
            seq_addr = (n == 3'd1 || n == 3'd4) ? CMD_A2 : CMD_A1;
        end
    endfunction

    // returns the data of step n; unlock repeats the first two bytes
    function [7:0] seq_data;
        input [2:0] n;
        input unlock;
        begin
            case (n)
                3'd0, 3'd3: seq_data = CMD_D1;
                3'd1, 3'd4: seq_data = CMD_D2;
                3'd2: seq_data = unlock ? UNLOCK_D3 : LOCK_D3;
                default: seq_data = UNLOCK_D6;
            endcase
        end
    endfunction

    wire unlock_op = (op_reg == OP_UNLOCK);
    wire [2:0] seq_len = unlock_op ? 3'd6 : 3'd3;
    // a prefix is needed for locking, unlocking, or any write while the lock is on
    wire need_prefix = (cmd_op != OP_READ) && (cmd_op != OP_PAGE || soft_write_lock);
    assign cmd_ready = (state_reg == S_IDLE) && write_inhibit_n;
    // a byte is taken only when the strobe unit is free; back-pressure holds the source
    assign load_ready = (state_reg == S_LOAD) && !go_reg && !st_busy && (left_reg != 8'h00);

    eew_strobe u_strobe (
        .clock(clock),
        .reset_n(reset_n),
        .start(go_reg),
        .is_read(go_read_reg),
        .addr(go_addr_reg),
        .wdata(go_data_reg),
        .mem_addr(mem_addr),
        .dq_out(dq_out),
        .dq_oe(dq_oe),
        .dq_in(dq_in),
        .chip_sel_n(chip_sel_n),
        .out_en_n(out_en_n),
        .write_n(write_n),
        .rdata(st_rdata),
        .busy(st_busy),
        .done(st_done)
    );

    // inhibit follows the request but never drops while a write is in flight,
    // nor at the edge that takes a command, or the new cycle would start inhibited
    always @(posedge clock or negedge reset_n) begin
        if (!reset_n)
            write_inhibit_n <= 1'b0;
        else if (state_reg == S_IDLE && !(cmd_valid && cmd_ready))
            write_inhibit_n <= ~inhibit_req;
    end

    // main sequencer: command prefix, page loads, then wait for the internal write
    always @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            state_reg <= S_IDLE;
            op_reg <= OP_READ;
            step_reg <= 3'd0;
            left_reg <= 8'h00;
            page_reg <= 17'h0_0000;
            col_reg <= 7'h00;
            last_reg <= 8'h00;
            tmr_reg <= 24'h00_0000;
            toggle_prev_reg <= 1'b1;
            first_poll_reg <= 1'b1;
            go_reg <= 1'b0;
            go_read_reg <= 1'b0;
            go_addr_reg <= 17'h0_0000;
            go_data_reg <= 8'h00;
            rd_data <= 8'h00;
            cmd_done <= 1'b0;
            cmd_error <= 1'b0;
            status_busy <= 1'b0;
        end else begin
            go_reg <= 1'b0;
            cmd_done <= 1'b0;
            tmr_reg <= tmr_reg + 24'h00_0001;
            case (state_reg)
                S_IDLE: begin
                    if (cmd_valid && cmd_ready) begin
                        op_reg <= cmd_op;
                        cmd_error <= 1'b0;
                        step_reg <= 3'd0;
                        page_reg <= {cmd_addr[16:`EEW_PAGE_LSB], 7'h00};
                        col_reg <= cmd_addr[6:0];
                        // length clipped to the page: 1 to 128 bytes
                        left_reg <= (cmd_len == 8'h00) ? 8'h01 :
                            (cmd_len > `EEW_PAGE_BYTES) ? 8'd128 : cmd_len;
                        if (cmd_op == OP_READ) begin
                            go_reg <= 1'b1;
                            go_read_reg <= 1'b1;
                            go_addr_reg <= cmd_addr;
                            state_reg <= S_READ;
                        end else if (need_prefix) begin
                            state_reg <= S_CMD;
                        end else begin
                            state_reg <= S_LOAD;
                        end
                    end
                end
                S_CMD: begin
                    if (!go_reg && !st_busy) begin
                        if (step_reg == seq_len) begin
                            // unlock data is never kept, so the cycle ends after the code
                            state_reg <= unlock_op ? S_WAIT : S_LOAD;
                            tmr_reg <= 24'h00_0000;
                            first_poll_reg <= 1'b1;
                        end else begin
                            go_reg <= 1'b1;
                            go_read_reg <= 1'b0;
                            go_addr_reg <= seq_addr(step_reg);
                            go_data_reg <= seq_data(step_reg, unlock_op);
                            step_reg <= step_reg + 3'd1;
                        end
                    end
                end
                S_LOAD: begin
                    if (load_valid && load_ready) begin
                        go_reg <= 1'b1;
                        go_read_reg <= 1'b0;
                        go_addr_reg <= {page_reg[16:7], col_reg};
                        go_data_reg <= load_data;
                        last_reg <= load_data;
                        col_reg <= col_reg + 7'h01;
                        left_reg <= left_reg - 8'h01;
                        tmr_reg <= 24'h00_0000;
                    end else if (!go_reg && !st_busy && left_reg == 8'h00) begin
                        // strobes now stay high: the device starts writing after the window
                        tmr_reg <= 24'h00_0000;
                        first_poll_reg <= 1'b1;
                        state_reg <= S_WAIT;
                    end else if (!go_reg && !st_busy && tmr_reg >= `EEW_GAP_CYC) begin
                        // source too slow: the page closes early with what was loaded
                        left_reg <= 8'h00;
                        cmd_error <= 1'b1;
                    end
                end
                S_WAIT: begin
                    status_busy <= 1'b1;
                    // let the load window lapse, then poll bit 6 at a fixed address
                    if (tmr_reg >= WINDOW_CYC) begin
                        go_reg <= 1'b1;
                        go_read_reg <= 1'b1;
                        go_addr_reg <= page_reg;
                        state_reg <= S_POLL;
                    end
                end
                S_POLL: begin
                    if (st_done) begin
                        toggle_prev_reg <= st_rdata[`EEW_TOGGLE_BIT];
                        first_poll_reg <= 1'b0;
                        // finished when bit 6 stopped toggling and pin released; bit 7 must show true data only if the last byte went to the polled address
                        if (!first_poll_reg && st_rdata[`EEW_TOGGLE_BIT] == toggle_prev_reg && ready_busy_n &&
                            (unlock_op || st_rdata[`EEW_POLL_BIT] == last_reg[`EEW_POLL_BIT] ||
                             (page_reg[6:0] != col_reg - 7'h01))) begin
                            state_reg <= S_DONE;
                        end else if (tmr_reg >= WRITE_CYC + WINDOW_CYC) begin
                            // write time exceeded; inhibit was held high throughout
                            cmd_error <= 1'b1;
                            state_reg <= S_DONE;
                        end else begin
                            go_reg <= 1'b1;
                            go_read_reg <= 1'b1;
                        end
                    end
                end
                S_READ: begin
                    if (st_done) begin
                        rd_data <= st_rdata;
                        state_reg <= S_DONE;
                    end
                end
                S_DONE: begin
                    status_busy <= 1'b0;
                    cmd_done <= 1'b1;
                    state_reg <= S_IDLE;
                end
                default: state_reg <= S_IDLE;
            endcase
        end
    end
endmodule // eew_host

// ---- rtl/eew_strobe.v ----
// eew_strobe.v: one bus cycle on the eeprom pins (write or read)
// assumes inputs synchronous to clock; write_inhibit_n handled by the caller
`timescale 1ns/1ps
`include "eew_defines.vh"
module eew_strobe (
    input wire clock,
    input wire reset_n,
    input wire start,
    input wire is_read,
    input wire [16:0] addr,
    input wire [7:0] wdata,
    output reg [16:0] mem_addr,
    output reg [7:0] dq_out,
    output reg dq_oe,
    input wire [7:0] dq_in,
    output reg chip_sel_n,
    output reg out_en_n,
    output reg write_n,
    output reg [7:0] rdata,
    output wire busy,
    output reg done
);
    localparam S_IDLE = 2'd0;
    localparam S_LOW = 2'd1;
    localparam S_HIGH = 2'd2;
    reg [1:0] state_reg;
    reg [7:0] cnt_reg;
    reg rd_reg;
    assign busy = (state_reg != S_IDLE);
    // strobe low for the whole pulse, then a recovery gap so pulses never look like glitches
    always @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            state_reg <= S_IDLE;
            cnt_reg <= 8'h00;
            rd_reg <= 1'b0;
            mem_addr <= 17'h0_0000;
            dq_out <= 8'h00;
            dq_oe <= 1'b0;
            chip_sel_n <= 1'b1;
            out_en_n <= 1'b1;
            write_n <= 1'b1;
            rdata <= 8'h00;
            done <= 1'b0;
        end else begin
            done <= 1'b0;
            case (state_reg)
                S_IDLE: begin
                    if (start) begin
                        // address driven on the same edge that lowers the strobes: latched on the later falling edge
                        mem_addr <= addr;
                        dq_out <= wdata;
                        dq_oe <= ~is_read;
                        rd_reg <= is_read;
                        chip_sel_n <= 1'b0;
                        out_en_n <= ~is_read;
                        write_n <= is_read;
                        cnt_reg <= 8'h00;
                        state_reg <= S_LOW;
                    end
                end
                S_LOW: begin
                    cnt_reg <= cnt_reg + 8'h01;
                    // pulse well above the noise filter width
                    if (cnt_reg == `EEW_STROBE_CYC - 1) begin
                        if (rd_reg)
                            rdata <= dq_in;
                        chip_sel_n <= 1'b1;
                        out_en_n <= 1'b1;
                        write_n <= 1'b1;
                        cnt_reg <= 8'h00;
                        state_reg <= S_HIGH;
                    end
                end
                S_HIGH: begin
                    cnt_reg <= cnt_reg + 8'h01;
                    // data held past the rising edge, then the bus is released
                    if (cnt_reg == `EEW_GLITCH_CYC) begin
                        dq_oe <= 1'b0;
                        done <= 1'b1;
                        state_reg <= S_IDLE;
                    end
                end
                default: state_reg <= S_IDLE;
            endcase
        end
    end
endmodule // eew_strobe
